// file: hdl/pcor_map.vh
// register map, field positions, reset values and timing counts of the offset ramp control
`ifndef PCOR_MAP_VH
`define PCOR_MAP_VH

// register byte addresses
`define PCOR_ADDR_THIRD_POLE     8'h00
`define PCOR_ADDR_XTAL_SWITCH    8'h04
`define PCOR_ADDR_OFFSET_CFG     8'h08
`define PCOR_ADDR_RAMP_STATUS    8'h0c

// third pole configuration fields
`define PCOR_TP_BYPASS_BIT       7
`define PCOR_TP_RES_MSB          6
`define PCOR_TP_RES_LSB          4
`define PCOR_TP_CAP_MSB          2
`define PCOR_TP_CAP_LSB          0
`define PCOR_TP_RESET            8'h44
`define PCOR_TP_WR_MASK          8'hf7

// crystal switch configuration fields
`define PCOR_XS_INTERVAL_MSB     29
`define PCOR_XS_INTERVAL_LSB     27
`define PCOR_XS_STEP_MSB         26
`define PCOR_XS_STEP_LSB         24
`define PCOR_XS_RAMP_EN_BIT      23
`define PCOR_XS_RESET            32'h09e1cf88
`define PCOR_XS_WR_MASK          32'h3fffffff

// offset configuration fields
`define PCOR_OC_OFFSET_MSB       3
`define PCOR_OC_OFFSET_LSB       0
`define PCOR_OC_BOOST_BIT        4
`define PCOR_OC_RESET            32'h00000000
`define PCOR_OC_WR_MASK          32'h0000001f

// ramp status fields
`define PCOR_RS_BOOST_BIT        4
`define PCOR_RS_BUSY_BIT         5

// third pole resistor step in ohms
`define PCOR_RES_STEP_OHM        13'd800

// time base
`define PCOR_CLK_PERIOD_NS       40
`define PCOR_STEP_UNIT_NS        1000
`define PCOR_CYC_PER_US          (`PCOR_STEP_UNIT_NS / `PCOR_CLK_PERIOD_NS)

`endif

// file: hdl/pcor_us_tick.v
// one microsecond tick generator with restart
`timescale 1ns/1ps
module pcor_us_tick
#(
   parameter CNT_W      = 8,
   parameter CYC_PER_US = 25
)
(
   input  wire ref_clk,
   input  wire rstn,
   input  wire restart,
   output reg  us_tick
);

   localparam integer     LAST_I = CYC_PER_US - 1;
   localparam [CNT_W-1:0] LAST   = LAST_I[CNT_W-1:0];

   reg [CNT_W-1:0] cnt_ff;

   // restart realigns the phase so the first interval is a full microsecond
   always @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         cnt_ff  <= {CNT_W{1'b0}};
         us_tick <= 1'b0;
      end
      else if (restart)
      begin
         // start at one: the tick is registered, so this keeps the first step on time
         cnt_ff  <= {{(CNT_W-1){1'b0}}, 1'b1};
         us_tick <= 1'b0;
      end
      else if (cnt_ff == LAST)
      begin
         cnt_ff  <= {CNT_W{1'b0}};
         us_tick <= 1'b1;
      end
      else
      begin
         cnt_ff  <= cnt_ff + 1'b1;
         us_tick <= 1'b0;
      end
   end

endmodule // pcor_us_tick

// file: hdl/pcor_ctrl.v
// third pole settings and charge-pump offset ramp after a crystal switch
`timescale 1ns/1ps
`include "pcor_map.vh"
module pcor_ctrl
#(
   parameter OFS_W = 4,
   parameter ADR_W = 8
)
(
   input  wire             ref_clk,
   input  wire             rstn,
   input  wire [ADR_W-1:0] addr,
   input  wire [31:0]      wr_data,
   input  wire             wr_en,
   input  wire             rd_en,
   output reg  [31:0]      rd_data,
   input  wire             xtal_switch,
   output reg              third_pole_bypass,
   output reg  [2:0]       third_pole_resistor_code,
   output reg  [12:0]      third_pole_resistance_ohm,
   output reg  [2:0]       third_pole_capacitor_code,
   output reg  [OFS_W-1:0] working_pump_offset,
   output reg              working_offset_boost
);

   // one-hot ramp states
   localparam [3:0] ST_IDLE  = 4'h1;
   localparam [3:0] ST_RAMP  = 4'h2;
   localparam [3:0] ST_BWAIT = 4'h4;
   localparam [3:0] ST_ZWAIT = 4'h8;

   // zero codes are out of range; treat them as one so the ramp never stalls
   function [2:0] pcor_nonzero;
      input [2:0] v;
      begin
         pcor_nonzero = (v == 3'h0) ? 3'h1 : v;
      end
   endfunction

   function [12:0] pcor_res_ohm;
      input [2:0] c;
      begin
         pcor_res_ohm = {10'h000, c} * `PCOR_RES_STEP_OHM;
      end
   endfunction

   reg  [7:0]       tp_cfg_ff;
   reg  [31:0]      xs_cfg_ff;
   reg  [31:0]      oc_cfg_ff;
   reg  [3:0]       st_ff;
   reg  [3:0]       nxt_st;
   reg  [OFS_W-1:0] nxt_offset;
   reg              nxt_boost;
   reg  [2:0]       us_cnt_ff;
   reg  [2:0]       nxt_us_cnt;
   reg              second_ff;
   reg              nxt_second;
   reg              timer_restart;
   reg              sw_meta_ff;
   reg              sw_sync_ff;
   reg              sw_prev_ff;
   reg  [OFS_W:0]   step_sum;
   reg  [31:0]      nxt_rd_data;
   wire             us_tick;
   wire             sw_evt;
   wire             ramp_en;
   wire [2:0]       ivl_len;
   wire [2:0]       step_len;
   wire [OFS_W-1:0] prog_offset;
   wire             cfg_boost;
   wire             ivl_done;

   assign ramp_en     = xs_cfg_ff[`PCOR_XS_RAMP_EN_BIT];
   assign ivl_len     = pcor_nonzero(xs_cfg_ff[`PCOR_XS_INTERVAL_MSB:`PCOR_XS_INTERVAL_LSB]);
   assign step_len    = pcor_nonzero(xs_cfg_ff[`PCOR_XS_STEP_MSB:`PCOR_XS_STEP_LSB]);
   assign prog_offset = oc_cfg_ff[`PCOR_OC_OFFSET_MSB:`PCOR_OC_OFFSET_LSB];
   assign cfg_boost   = oc_cfg_ff[`PCOR_OC_BOOST_BIT];

   // microsecond base restarted with each sequence
   pcor_us_tick
   #(
      .CNT_W      (8),
      .CYC_PER_US (`PCOR_CYC_PER_US)
   )
   u_tick
   (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .restart (timer_restart),
      .us_tick (us_tick)
   );

   // switch detector output is asynchronous: two flops, then edge detect
   always @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         sw_meta_ff <= 1'b0;
         sw_sync_ff <= 1'b0;
         sw_prev_ff <= 1'b0;
      end
      else
      begin
         sw_meta_ff <= xtal_switch;
         sw_sync_ff <= sw_meta_ff;
         sw_prev_ff <= sw_sync_ff;
      end
   end

   assign sw_evt = sw_sync_ff & ~sw_prev_ff;

   // interval ends when the tick count reaches the interval code
   assign ivl_done = us_tick & ({1'b0, us_cnt_ff} + 4'h1 >= {1'b0, ivl_len});

   // register writes; reserved bits are masked so they read as zero
   always @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         tp_cfg_ff <= `PCOR_TP_RESET;
         xs_cfg_ff <= `PCOR_XS_RESET;
         oc_cfg_ff <= `PCOR_OC_RESET;
      end
      else if (wr_en)
      begin
         if (addr == `PCOR_ADDR_THIRD_POLE)
         begin
            tp_cfg_ff <= wr_data[7:0] & `PCOR_TP_WR_MASK;
         end
         else if (addr == `PCOR_ADDR_XTAL_SWITCH)
         begin
            xs_cfg_ff <= wr_data & `PCOR_XS_WR_MASK;
         end
         else if (addr == `PCOR_ADDR_OFFSET_CFG)
         begin
            oc_cfg_ff <= wr_data & `PCOR_OC_WR_MASK;
         end
      end
   end

   // read mux; unmapped addresses read zero
   always @*
   begin
      nxt_rd_data = 32'h00000000;
      if (addr == `PCOR_ADDR_THIRD_POLE)
      begin
         nxt_rd_data = {24'h000000, tp_cfg_ff};
      end
      else if (addr == `PCOR_ADDR_XTAL_SWITCH)
      begin
         nxt_rd_data = xs_cfg_ff;
      end
      else if (addr == `PCOR_ADDR_OFFSET_CFG)
      begin
         nxt_rd_data = oc_cfg_ff;
      end
      else if (addr == `PCOR_ADDR_RAMP_STATUS)
      begin
         nxt_rd_data[OFS_W-1:0]         = working_pump_offset;
         nxt_rd_data[`PCOR_RS_BOOST_BIT] = working_offset_boost;
         nxt_rd_data[`PCOR_RS_BUSY_BIT]  = ~st_ff[0];
      end
   end

   // read data valid only in the cycle after the strobe
   always @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         rd_data <= 32'h00000000;
      end
      else if (rd_en)
      begin
         rd_data <= nxt_rd_data;
      end
      else
      begin
         rd_data <= 32'h00000000;
      end
   end

   // third pole outputs; bypass use is software's concern with integer divider
   always @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         third_pole_bypass         <= 1'b0;
         third_pole_resistor_code  <= 3'h4;
         third_pole_resistance_ohm <= pcor_res_ohm(3'h4);
         third_pole_capacitor_code <= 3'h4;
      end
      else
      begin
         third_pole_bypass         <= tp_cfg_ff[`PCOR_TP_BYPASS_BIT];
         third_pole_resistor_code  <= tp_cfg_ff[`PCOR_TP_RES_MSB:`PCOR_TP_RES_LSB];
         third_pole_resistance_ohm <=
            pcor_res_ohm(tp_cfg_ff[`PCOR_TP_RES_MSB:`PCOR_TP_RES_LSB]);
         // capacitor code is already the value in pF
         third_pole_capacitor_code <= tp_cfg_ff[`PCOR_TP_CAP_MSB:`PCOR_TP_CAP_LSB];
      end
   end

   // ramp sequencer next state
   always @*
   begin
      nxt_st        = st_ff;
      nxt_offset    = working_pump_offset;
      nxt_boost     = working_offset_boost;
      nxt_us_cnt    = us_cnt_ff;
      nxt_second    = second_ff;
      timer_restart = 1'b0;
      step_sum      = {1'b0, working_pump_offset} + {{(OFS_W-2){1'b0}}, step_len};
      if (us_tick)
      begin
         nxt_us_cnt = ivl_done ? 3'h0 : us_cnt_ff + 3'h1;
      end
      case (st_ff)
         ST_IDLE:
         begin
            // at rest the working values follow the programmed ones
            nxt_offset = prog_offset;
            nxt_boost  = cfg_boost;
         end
         ST_RAMP:
         begin
            if (ivl_done)
            begin
               if (step_sum >= {1'b0, prog_offset})
               begin
                  nxt_offset = prog_offset;
                  nxt_st     = ST_BWAIT;
               end
               else
               begin
                  nxt_offset = step_sum[OFS_W-1:0];
               end
            end
            else if (working_pump_offset > prog_offset)
            begin
               // software lowered the target mid-ramp
               nxt_offset = prog_offset;
            end
         end
         ST_BWAIT:
         begin
            nxt_offset = prog_offset;
            if (ivl_done)
            begin
               nxt_boost = cfg_boost;
               nxt_st    = ST_IDLE;
            end
         end
         ST_ZWAIT:
         begin
            nxt_offset = prog_offset;
            if (ivl_done)
            begin
               if (second_ff)
               begin
                  nxt_boost = cfg_boost;
                  nxt_st    = ST_IDLE;
               end
               else
               begin
                  nxt_second = 1'b1;
               end
            end
         end
         default:
         begin
            nxt_st = ST_IDLE;
         end
      endcase
      // a switch with ramp disabled changes nothing
      if (sw_evt && ramp_en)
      begin
         nxt_offset    = {OFS_W{1'b0}};
         nxt_boost     = 1'b0;
         nxt_us_cnt    = 3'h0;
         nxt_second    = 1'b0;
         timer_restart = 1'b1;
         nxt_st        = (prog_offset == {OFS_W{1'b0}}) ? ST_ZWAIT : ST_RAMP;
      end
   end

   // ramp sequencer state and working outputs
   always @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         st_ff                <= ST_IDLE;
         working_pump_offset  <= {OFS_W{1'b0}};
         working_offset_boost <= 1'b0;
         us_cnt_ff            <= 3'h0;
         second_ff            <= 1'b0;
      end
      else
      begin
         st_ff                <= nxt_st;
         working_pump_offset  <= nxt_offset;
         working_offset_boost <= nxt_boost;
         us_cnt_ff            <= nxt_us_cnt;
         second_ff            <= nxt_second;
      end
   end

endmodule // pcor_ctrl

// file: verification/pcor_ctrl_properties.sv
// port assertions for the offset ramp control
`timescale 1ns/1ps
`include "pcor_map.vh"
module pcor_props
#(
   parameter OFS_W = 4,
   parameter ADR_W = 8
)
(
   input wire             ref_clk,
   input wire             rstn,
   input wire [ADR_W-1:0] addr,
   input wire [31:0]      wr_data,
   input wire             wr_en,
   input wire             rd_en,
   input wire [31:0]      rd_data,
   input wire             xtal_switch,
   input wire             third_pole_bypass,
   input wire [2:0]       third_pole_resistor_code,
   input wire [12:0]      third_pole_resistance_ohm,
   input wire [2:0]       third_pole_capacitor_code,
   input wire [OFS_W-1:0] working_pump_offset,
   input wire             working_offset_boost
);
   reg [OFS_W-1:0] prog_ff;
   reg [OFS_W-1:0] last_ff;
   reg [6:0]       xs_ff;
   reg             bst_ff;
   reg [9:0]       gap_ff;
   wire [OFS_W:0]  nxt_ofs = last_ff + xs_ff[3:1];
   wire            rising  = working_pump_offset > last_ff && last_ff != 0;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   // shadow settings, the checker only sees the bus
   always @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         {bst_ff, prog_ff} <= {(OFS_W+1){1'b0}};
         xs_ff <= 7'h13;
      end
      else if (wr_en && addr == `PCOR_ADDR_OFFSET_CFG)
         {bst_ff, prog_ff} <= wr_data[OFS_W:0];
      else if (wr_en && addr == `PCOR_ADDR_XTAL_SWITCH)
         xs_ff <= wr_data[29:23];
   end

   // cycles since the working offset last moved
   always @(posedge ref_clk)
   begin
      last_ff <= rstn ? working_pump_offset : {OFS_W{1'b0}};
      gap_ff  <= (!rstn || working_pump_offset != last_ff) ? 10'h001 : gap_ff + 10'h001;
   end

   res_decode_a: assert property (
      third_pole_resistance_ohm == third_pole_resistor_code * 13'h320)
      else $error("resistance off its code");
   pole_write_a: assert property (
      wr_en && addr == `PCOR_ADDR_THIRD_POLE |=> ##1 {third_pole_bypass,
      third_pole_resistor_code, third_pole_capacitor_code} ==
      {$past(wr_data[7:4], 2), $past(wr_data[2:0], 2)})
      else $error("third pole outputs not written");
   pole_read_a: assert property (
      rd_en && addr == `PCOR_ADDR_THIRD_POLE |=> rd_data == {24'h0, third_pole_bypass,
      third_pole_resistor_code, 1'h0, third_pole_capacitor_code})
      else $error("third pole readback wrong");
   switch_zero_a: assert property (
      $rose(xtal_switch) && xs_ff[0] |-> ##4 working_pump_offset == 0 && !working_offset_boost)
      else $error("switch did not zero offset");
   ramp_off_a: assert property (
      $rose(xtal_switch) && !xs_ff[0] |-> ##1
      $stable({working_offset_boost, working_pump_offset}) [*5])
      else $error("disabled ramp moved offset");
   step_size_a: assert property (
      rising && $past(prog_ff, 2) == prog_ff |->
      working_pump_offset == ((nxt_ofs > prog_ff) ? prog_ff : nxt_ofs))
      else $error("ramp step size wrong");
   step_gap_a: assert property (
      rising && $past(prog_ff, 2) == prog_ff |-> gap_ff == xs_ff[6:4] * `PCOR_CYC_PER_US)
      else $error("ramp step spacing wrong");
   boost_wait_a: assert property (
      $rose(working_offset_boost) && prog_ff != 0 && $past(bst_ff, 2) == bst_ff |->
      gap_ff == xs_ff[6:4] * `PCOR_CYC_PER_US)
      else $error("boost restored at wrong time");
   offset_clamp_a: assert property (
      $past(prog_ff) == prog_ff |-> working_pump_offset <= prog_ff)
      else $error("offset above programmed value");
endmodule // pcor_props

bind pcor_ctrl pcor_props #(.OFS_W(OFS_W), .ADR_W(ADR_W)) u_props (.ref_clk(ref_clk),
   .rstn(rstn), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
   .rd_data(rd_data), .xtal_switch(xtal_switch), .third_pole_bypass(third_pole_bypass),
   .third_pole_resistor_code(third_pole_resistor_code),
   .third_pole_resistance_ohm(third_pole_resistance_ohm),
   .third_pole_capacitor_code(third_pole_capacitor_code),
   .working_pump_offset(working_pump_offset), .working_offset_boost(working_offset_boost));

// file: verification/testbench.sv
// self-checking bench for the offset ramp control
`timescale 1ns/1ps
`include "pcor_map.vh"
module testbench;
   localparam CYC = `PCOR_CYC_PER_US;
   reg         ref_clk;
   reg         rstn;
   reg  [7:0]  addr;
   reg  [31:0] wr_data;
   reg         wr_en;
   reg         rd_en;
   reg         xtal_switch;
   wire [31:0] rd_data;
   wire        bypass;
   wire [2:0]  res_code;
   wire [12:0] res_ohm;
   wire [2:0]  cap_code;
   wire [3:0]  offset;
   wire        boost;
   reg  [31:0] seed;
   integer     num_errors;
   integer     checked;
   integer     cycles;
   integer     k;

   pcor_ctrl dut (.ref_clk(ref_clk), .rstn(rstn), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .xtal_switch(xtal_switch),
      .third_pole_bypass(bypass), .third_pole_resistor_code(res_code),
      .third_pole_resistance_ohm(res_ohm), .third_pole_capacitor_code(cap_code),
      .working_pump_offset(offset), .working_offset_boost(boost));

   // xorshift source, fixed start keeps runs repeatable
   function [31:0] xs(input [31:0] x);
      reg [31:0] y;
      begin
         y = x ^ (x << 13);
         y = y ^ (y >> 17);
         xs = y ^ (y << 5);
      end
   endfunction
   function [12:0] ohm(input [2:0] c);
      ohm = c * 13'h320;
   endfunction
   // next ramp value, clamped so the last step never overshoots
   function [3:0] nxt_step(input [3:0] v, input [2:0] s, input [3:0] p);
      nxt_step = ({1'b0, v} + s > {1'b0, p}) ? p : v + s;
   endfunction

   task chk(input [31:0] s, input [31:0] e);
      begin
         checked = checked + 1;
         if (s !== e)
         begin
            num_errors = num_errors + 1;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
         end
      end
   endtask
   task conclude;
      begin
         $display("errors %0d checks %0d", num_errors, checked);
         if (num_errors == 0 && checked > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   task cyc(input integer n);
      begin
         repeat (n) @(posedge ref_clk);
         #1;
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      begin
         @(posedge ref_clk);
         wr_en <= 1'b1;
         addr <= a;
         wr_data <= d;
         @(posedge ref_clk);
         wr_en <= 1'b0;
         #1;
      end
   endtask
   task rd(input [7:0] a, input [31:0] e);
      begin
         @(posedge ref_clk);
         rd_en <= 1'b1;
         addr <= a;
         @(posedge ref_clk);
         rd_en <= 1'b0;
         #1;
         chk(rd_data, e);
      end
   endtask
   // switch indication held two cycles so the synchroniser sees it
   task pulse;
      begin
         @(posedge ref_clk);
         xtal_switch <= 1'b1;
         cyc(2);
         xtal_switch <= 1'b0;
      end
   endtask
   task anchor;
      integer n;
      begin
         n = 0;
         while ((offset !== 4'h0 || boost !== 1'b0) && n < 20)
         begin
            cyc(1);
            n = n + 1;
         end
         chk({boost, offset}, 5'h00);
      end
   endtask
   // one switch and the whole ramp back, optional second switch mid-way
   task ramp(input [3:0] p, input [2:0] s, input [2:0] i, input b, input rs);
      reg [3:0] v;
      begin
         wr(8'h04, {2'h0, i, s, 1'b1, 23'h61cf88});
         wr(8'h08, {27'h0, b, p});
         cyc(2);
         pulse;
         anchor;
         rd(8'h0c, 32'h20);
         cyc(i * CYC - 2);
         v = 4'h0;
         while (v != p)
         begin
            v = nxt_step(v, s, p);
            chk(offset, v);
            if (rs)
            begin
               rs = 1'b0;
               v = 4'h0;
               pulse;
               anchor;
               cyc(i * CYC);
            end
            else if (v != p)
               cyc(i * CYC);
         end
         chk(boost, 1'b0);
         cyc(i * CYC);
         chk(boost, b);
         rd(8'h0c, {27'h0, b, p});
      end
   endtask

   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // cycle ceiling against a hung design
   always @(posedge ref_clk)
   begin
      cycles = cycles + 1;
      if (cycles == 20000)
      begin
         num_errors = num_errors + 1;
         conclude;
      end
   end
   initial
   begin
      {rstn, wr_en, rd_en, xtal_switch} = 4'h0;
      addr = 8'h00;
      wr_data = 32'h0;
      seed = 32'h00013b02;
      num_errors = 0;
      checked = 0;
      cycles = 0;
      repeat (6) @(posedge ref_clk);
      rstn <= 1'b1;
      cyc(1);
      chk({bypass, res_code, cap_code, res_ohm}, {7'h24, 13'hc80});
      rd(8'h00, 32'h44);
      rd(8'h04, 32'h09e1cf88);
      rd(8'h08, 32'h0);
      for (k = 0; k < 8; k = k + 1)
      begin
         seed = xs(seed);
         wr(8'h00, {seed[31:8], seed[7], k[2:0], seed[3], ~k[2:0]});
         // outputs follow the register one cycle after the write is taken
         cyc(1);
         chk({bypass, res_code, cap_code}, {seed[7], k[2:0], ~k[2:0]});
         chk(res_ohm, ohm(k[2:0]));
         rd(8'h00, {24'h0, seed[7], k[2:0], 1'h0, ~k[2:0]});
      end
      wr(8'h10, seed);
      rd(8'h10, 32'h0);
      wr(8'h04, 32'hffffffff);
      rd(8'h04, 32'h3fffffff);
      ramp(4'h5, 3'h2, 3'h1, 1'b1, 1'b0);
      ramp(4'hf, 3'h7, 3'h2, 1'b1, 1'b0);
      ramp(4'h3, 3'h1, 3'h7, 1'b0, 1'b1);
      ramp(4'h0, 3'h3, 3'h1, 1'b1, 1'b0);
      for (k = 0; k < 4; k = k + 1)
      begin
         seed = xs(seed);
         ramp(seed[15:12] | 4'h1, seed[6:4] % 3'h7 + 3'h1, seed[9:8] % 2'h3 + 2'h1,
            seed[16], seed[20]);
      end
      wr(8'h04, 32'h09000000);
      wr(8'h08, 32'h16);
      cyc(3);
      pulse;
      cyc(8);
      chk({boost, offset}, 5'h16);
      conclude;
   end
endmodule // testbench
